// [src/eal_addsub.sv]
// eight-bit adder and subtractor with carry, half-carry and overflow
`timescale 1ns/1ps

module eal_addsub import eal_pkg::*; #(
	parameter int W = DATA_W
) (
	// operands
	input wire logic [W-1:0] opA,
	input wire logic [W-1:0] opB,
	input wire logic carryIn,
	input wire logic subtract,
	// outputs
	output logic [W-1:0] sum,
	output logic carryOut,
	output logic halfOut,
	output logic ovfOut
);

	// half carry is taken from bit 3, so narrower words cannot be served
	if (W < 5) begin : g_width_check
		$error("width too small for half carry");
	end

	logic [W:0] wide;

	always_comb begin
		if (subtract) begin
			wide = {1'b0, opA} - {1'b0, opB} - {{W{1'b0}}, carryIn};
		end else begin
			wide = {1'b0, opA} + {1'b0, opB} + {{W{1'b0}}, carryIn};
		end
	end

	assign sum = wide[W-1:0];
	// bit w is carry on add and borrow on subtract
	assign carryOut = wide[W];
	assign halfOut = subtract ?
		((~opA[3] & opB[3]) | (opB[3] & sum[3]) | (sum[3] & ~opA[3])) :
		((opA[3] & opB[3]) | (opB[3] & ~sum[3]) | (~sum[3] & opA[3]));
	assign ovfOut = subtract ?
		((opA[W-1] & ~opB[W-1] & ~sum[W-1]) | (~opA[W-1] & opB[W-1] & sum[W-1])) :
		((opA[W-1] & opB[W-1] & ~sum[W-1]) | (~opA[W-1] & ~opB[W-1] & sum[W-1]));

endmodule : eal_addsub

// [src/eal_arith_logic_unit.sv]
// eight-bit arithmetic and logic unit with apb register access
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module eal_arith_logic_unit import eal_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// status
	output logic busy
);

	//////////////////////////////////////////////////////////////////////////
	// registers and state

	eal_state_t state;
	eal_state_t next_state;
	eal_op_t opReg;
	logic [DATA_W-1:0] dest, destHi, sourceReg, immediate;
	logic [FLAGS_W-1:0] flags;
	logic carrySave, lowZero;

	//////////////////////////////////////////////////////////////////////////
	// apb decode

	logic setupDone, accessEdge;
	logic hitCtrl, hitDest, hitDestHi, hitSrc, hitImm, hitFlags, hitResult;
	logic mapped, writeBlocked, badAccess, wrOk, startReq;
	logic [31:0] readMux;

	assign setupDone = psel & penable & ~pready;
	assign accessEdge = psel & penable & pready;

	always_comb begin
		hitCtrl = 1'b0;
		hitDest = 1'b0;
		hitDestHi = 1'b0;
		hitSrc = 1'b0;
		hitImm = 1'b0;
		hitFlags = 1'b0;
		hitResult = 1'b0;
		if (paddr == OFF_CTRL) begin
			hitCtrl = 1'b1;
		end else if (paddr == OFF_DEST) begin
			hitDest = 1'b1;
		end else if (paddr == OFF_DEST_HI) begin
			hitDestHi = 1'b1;
		end else if (paddr == OFF_SRC) begin
			hitSrc = 1'b1;
		end else if (paddr == OFF_IMM) begin
			hitImm = 1'b1;
		end else if (paddr == OFF_FLAGS) begin
			hitFlags = 1'b1;
		end else if (paddr == OFF_RESULT) begin
			hitResult = 1'b1;
		end
	end

	assign mapped = hitCtrl | hitDest | hitDestHi | hitSrc | hitImm | hitFlags | hitResult;
	// operands and flags are frozen while an operation runs
	assign writeBlocked = pwrite & (hitResult | (state != ST_IDLE));
	assign badAccess = ~mapped | writeBlocked;
	// refusal is fixed in the first access cycle; an op ending before pready must not let it land
	assign wrOk = accessEdge & pwrite & ~pslverr;
	assign startReq = wrOk & hitCtrl & pwdata[CTRL_START_BIT];

	always_comb begin
		readMux = 32'h0000_0000;
		if (hitCtrl) begin
			readMux[CTRL_OP_LSB +: CTRL_OP_W] = opReg;
			readMux[CTRL_BUSY_BIT] = (state != ST_IDLE);
		end else if (hitDest) begin
			readMux[DATA_W-1:0] = dest;
		end else if (hitDestHi) begin
			readMux[DATA_W-1:0] = destHi;
		end else if (hitSrc) begin
			readMux[DATA_W-1:0] = sourceReg;
		end else if (hitImm) begin
			readMux[DATA_W-1:0] = immediate;
		end else if (hitFlags) begin
			readMux[FLAGS_W-1:0] = flags;
		end else if (hitResult) begin
			readMux[2*DATA_W-1:0] = {destHi, dest};
		end
	end

	// one wait cycle: pready rises in the second access cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setupDone) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : readMux;
			pslverr <= badAccess;
		end else begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// datapath

	logic wordHigh, isWordOp, isSubWord, isLogic;
	logic [DATA_W-1:0] aluA, aluB, aluSum;
	logic aluCin, aluSub, aluCarry, aluHalf, aluOvf;
	eal_logic_t logicSel;
	logic [DATA_W-1:0] logicA, logicB, logicRes;

	assign wordHigh = (state == ST_WORD_HI);
	assign isWordOp = (opReg == OP_WORD_IMMEDIATE_PLUS) | (opReg == OP_WORD_IMMEDIATE_MINUS);
	assign isSubWord = (opReg == OP_WORD_IMMEDIATE_MINUS);

	always_comb begin
		aluA = dest;
		aluB = sourceReg;
		aluCin = 1'b0;
		aluSub = 1'b0;
		if (wordHigh) begin
			// high byte only absorbs the low byte's carry or borrow
			aluA = destHi;
			aluB = BYTE_ZERO;
			aluCin = carrySave;
			aluSub = isSubWord;
		end else begin
			case (opReg)
				OP_ADD: aluB = sourceReg;
				OP_ADD_CARRY: aluCin = flags[FL_C];
				OP_WORD_IMMEDIATE_PLUS: aluB = immediate;
				OP_SUB: aluSub = 1'b1;
				OP_DIFFERENCE_CONST: begin
					aluB = immediate;
					aluSub = 1'b1;
				end
				OP_DIFFERENCE_WITH_BORROW: begin
					aluSub = 1'b1;
					aluCin = flags[FL_C];
				end
				OP_DIFFERENCE_CONST_BORROW: begin
					aluB = immediate;
					aluSub = 1'b1;
					aluCin = flags[FL_C];
				end
				OP_WORD_IMMEDIATE_MINUS: begin
					aluB = immediate;
					aluSub = 1'b1;
				end
				OP_TWOS_INVERT: begin
					aluA = BYTE_ZERO;
					aluB = dest;
					aluSub = 1'b1;
				end
				default: aluB = sourceReg;
			endcase
		end
	end

	eal_addsub #(
		.W(DATA_W)
	) u_addsub (
		.opA(aluA),
		.opB(aluB),
		.carryIn(aluCin),
		.subtract(aluSub),
		.sum(aluSum),
		.carryOut(aluCarry),
		.halfOut(aluHalf),
		.ovfOut(aluOvf)
	);

	always_comb begin
		logicSel = LG_AND;
		logicA = dest;
		logicB = sourceReg;
		isLogic = 1'b1;
		case (opReg)
			OP_AND: logicSel = LG_AND;
			OP_CONJUNCTION_CONST: begin
				logicSel = LG_AND;
				logicB = immediate;
			end
			OP_OR: logicSel = LG_OR;
			OP_DISJUNCTION_CONST: begin
				logicSel = LG_OR;
				logicB = immediate;
			end
			OP_BITWISE_PARITY_REGS: logicSel = LG_XOR;
			OP_BITS_SET_MASK: begin
				logicSel = LG_OR;
				logicB = immediate;
			end
			OP_BITS_CLEAR_MASK: begin
				logicSel = LG_CLEAR;
				logicB = immediate;
			end
			OP_ONES_INVERT: logicSel = LG_INVERT;
			default: isLogic = 1'b0;
		endcase
	end

	eal_logic #(
		.W(DATA_W)
	) u_logic (
		.opA(logicA),
		.opB(logicB),
		.sel(logicSel),
		.res(logicRes)
	);

	//////////////////////////////////////////////////////////////////////////
	// result and flag selection

	logic [DATA_W-1:0] byteRes;
	logic [FLAGS_W-1:0] next_flags;
	logic wordZero, wordNeg;

	assign byteRes = isLogic ? logicRes : aluSum;
	assign wordZero = (aluSum == BYTE_ZERO) & lowZero;
	assign wordNeg = aluSum[DATA_W-1];

	always_comb begin
		// untouched flags keep their value
		next_flags = flags;
		if (wordHigh) begin
			next_flags[FL_Z] = wordZero;
			next_flags[FL_C] = aluCarry;
			next_flags[FL_N] = wordNeg;
			next_flags[FL_V] = aluOvf;
			next_flags[FL_S] = wordNeg ^ aluOvf;
		end else if (opReg == OP_ONES_INVERT) begin
			next_flags[FL_Z] = (logicRes == BYTE_ZERO);
			next_flags[FL_C] = 1'b1;
			next_flags[FL_N] = logicRes[DATA_W-1];
			next_flags[FL_V] = 1'b0;
		end else if (isLogic) begin
			next_flags[FL_Z] = (logicRes == BYTE_ZERO);
			next_flags[FL_N] = logicRes[DATA_W-1];
			next_flags[FL_V] = 1'b0;
		end else begin
			next_flags[FL_Z] = (aluSum == BYTE_ZERO);
			next_flags[FL_C] = aluCarry;
			next_flags[FL_N] = aluSum[DATA_W-1];
			next_flags[FL_V] = aluOvf;
			next_flags[FL_H] = aluHalf;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (startReq) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// word forms need a second clock for the high byte
				next_state = isWordOp ? ST_WORD_HI : ST_IDLE;
			end
			ST_WORD_HI: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			busy <= (next_state != ST_IDLE);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			opReg <= OP_ADD;
		end else if (wrOk & hitCtrl) begin
			opReg <= eal_op_t'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sourceReg <= DEST_RST;
			immediate <= DEST_RST;
		end else if (wrOk & hitSrc) begin
			sourceReg <= pwdata[DATA_W-1:0];
		end else if (wrOk & hitImm) begin
			immediate <= pwdata[DATA_W-1:0];
		end
	end

	// low byte of the destination pair
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dest <= DEST_RST;
		end else if (state == ST_EXEC) begin
			dest <= byteRes;
		end else if (wrOk & hitDest) begin
			dest <= pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			destHi <= DEST_RST;
		end else if (wordHigh) begin
			destHi <= aluSum;
		end else if (wrOk & hitDestHi) begin
			destHi <= pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			carrySave <= 1'b0;
			lowZero <= 1'b0;
		end else if ((state == ST_EXEC) & isWordOp) begin
			carrySave <= aluCarry;
			lowZero <= (aluSum == BYTE_ZERO);
		end
	end

	// flags change at the end of an operation or on a write to the flags register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags <= FLAGS_RST;
		end else if ((state == ST_EXEC) & ~isWordOp) begin
			flags <= next_flags;
		end else if (wordHigh) begin
			flags <= next_flags;
		end else if (wrOk & hitFlags) begin
			flags <= pwdata[FLAGS_W-1:0];
		end
	end

endmodule : eal_arith_logic_unit

// [src/eal_logic.sv]
// bitwise logic unit: and, or, exclusive or, invert, clear by mask
`timescale 1ns/1ps

module eal_logic import eal_pkg::*; #(
	parameter int W = DATA_W
) (
	// operands
	input wire logic [W-1:0] opA,
	input wire logic [W-1:0] opB,
	input wire eal_logic_t sel,
	// output
	output logic [W-1:0] res
);

	always_comb begin
		case (sel)
			LG_AND: res = opA & opB;
			LG_OR: res = opA | opB;
			LG_XOR: res = opA ^ opB;
			LG_INVERT: res = {W{1'b1}} - opA;
			LG_CLEAR: res = opA & ({W{1'b1}} - opB);
			default: res = opA;
		endcase
	end

endmodule : eal_logic

// [src/eal_pkg.sv]
// constants, opcodes and register map of the eight-bit arithmetic and logic unit
package eal_pkg;

	localparam int DATA_W = 8;
	localparam int APB_AW = 8;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DEST = 8'h04;
	localparam logic [7:0] OFF_DEST_HI = 8'h08;
	localparam logic [7:0] OFF_SRC = 8'h0c;
	localparam logic [7:0] OFF_IMM = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	localparam logic [7:0] OFF_RESULT = 8'h18;

	// control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 5;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_BUSY_BIT = 9;

	// status flag positions
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FLAGS_W = 6;

	// reset values and byte constants
	localparam logic [7:0] DEST_RST = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// operation codes
	typedef enum logic [4:0] {
		OP_ADD = 5'h00,
		OP_ADD_CARRY = 5'h01,
		OP_WORD_IMMEDIATE_PLUS = 5'h02,
		OP_SUB = 5'h03,
		OP_DIFFERENCE_CONST = 5'h04,
		OP_DIFFERENCE_WITH_BORROW = 5'h05,
		OP_DIFFERENCE_CONST_BORROW = 5'h06,
		OP_WORD_IMMEDIATE_MINUS = 5'h07,
		OP_AND = 5'h08,
		OP_CONJUNCTION_CONST = 5'h09,
		OP_OR = 5'h0a,
		OP_DISJUNCTION_CONST = 5'h0b,
		OP_BITWISE_PARITY_REGS = 5'h0c,
		OP_ONES_INVERT = 5'h0d,
		OP_TWOS_INVERT = 5'h0e,
		OP_BITS_SET_MASK = 5'h0f,
		OP_BITS_CLEAR_MASK = 5'h10
	} eal_op_t;

	// logic unit selects
	typedef enum logic [2:0] {
		LG_AND = 3'h0,
		LG_OR = 3'h1,
		LG_XOR = 3'h2,
		LG_INVERT = 3'h3,
		LG_CLEAR = 3'h4
	} eal_logic_t;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_WORD_HI = 3'b100
	} eal_state_t;

endpackage : eal_pkg

// [verification/eal_alu_properties.sv]
// port checker for the arithmetic and logic unit
`timescale 1ns/1ps
module eal_alu_properties import eal_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status
	input wire logic busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic done;
	logic start;
	logic wordOp;
	assign done = psel && penable && pready;
	assign start = done && pwrite && paddr == OFF_CTRL && pwdata[CTRL_START_BIT] && !pslverr;
	// word ops need a second cycle for the high byte
	assign wordOp = pwdata[CTRL_OP_LSB +: CTRL_OP_W] == OP_WORD_IMMEDIATE_PLUS ||
		pwdata[CTRL_OP_LSB +: CTRL_OP_W] == OP_WORD_IMMEDIATE_MINUS;
	////////////////////////////////////////
	ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	quiet_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("response outside pready");
	byte_time_a: assert property (start && !wordOp |=> busy ##1 !busy)
		else $error("byte op not one clock");
	word_time_a: assert property (start && wordOp |=> busy [*2] ##1 !busy)
		else $error("word op not two clocks");
	busy_cause_a: assert property ($rose(busy) |-> $past(start)) else $error("busy without start");
	bad_addr_a: assert property (done && (paddr > OFF_RESULT || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped access accepted");
	result_ro_a: assert property (done && pwrite && paddr == OFF_RESULT |-> pslverr)
		else $error("result write accepted");
	cover property (start && !wordOp);
	cover property (start && wordOp);
	cover property (done && pslverr);
endmodule : eal_alu_properties

bind eal_arith_logic_unit eal_alu_properties chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .busy(busy));

// [verification/eal_apb_master.sv]
// apb master standing in for the core decoder and register file
`timescale 1ns/1ps
module eal_apb_master import eal_pkg::*; (
	// clock
	input wire logic ref_clk,
	// apb
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [APB_AW-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// psel stays up after a held transfer, so the next setup follows at once
	logic held;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		held = 1'b0;
	end
	////////////////////////////////////////
	// every signal moves just after a rising edge; pready is taken at the edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			input logic keep, output logic [31:0] rd, output logic err);
		if (!held)
			@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
		if (!keep)
			psel <= 1'b0;
		held = keep;
	endtask : xfer
endmodule : eal_apb_master

// [verification/eal_arith_logic_unit_tb.sv]
// self-checking bench for the arithmetic and logic unit
`timescale 1ns/1ps
module eal_arith_logic_unit_tb import eal_pkg::*; ;
	logic ref_clk;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, busy, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	typedef struct {eal_op_t op; logic [7:0] d, dh, s, k; logic [5:0] fi;
		logic [7:0] ed, edh; logic [5:0] fo;} eal_row_t;
	// op, dest, dest_hi, src, imm, flags in -> dest, dest_hi, flags out
	eal_row_t rows [18] = '{
		'{OP_ADD, 8'h0f, 8'h3c, 8'h01, 8'h55, 6'h10, 8'h10, 8'h3c, 6'h30},
		'{OP_ADD_CARRY, 8'h7f, 8'h3c, 8'h00, 8'h55, 6'h01, 8'h80, 8'h3c, 6'h2c},
		'{OP_WORD_IMMEDIATE_PLUS, 8'hff, 8'hff, 8'h55, 8'h01, 6'h20, 8'h00, 8'h00, 6'h23},
		'{OP_SUB, 8'h10, 8'h3c, 8'h01, 8'h55, 6'h00, 8'h0f, 8'h3c, 6'h20},
		'{OP_DIFFERENCE_CONST, 8'h00, 8'h3c, 8'h55, 8'h01, 6'h00, 8'hff, 8'h3c, 6'h25},
		'{OP_DIFFERENCE_WITH_BORROW, 8'h80, 8'h3c, 8'h00, 8'h55, 6'h01, 8'h7f, 8'h3c, 6'h28},
		'{OP_DIFFERENCE_CONST_BORROW, 8'h05, 8'h3c, 8'h55, 8'h04, 6'h01, 8'h00, 8'h3c, 6'h02},
		'{OP_WORD_IMMEDIATE_MINUS, 8'h00, 8'h00, 8'h55, 8'h01, 6'h00, 8'hff, 8'hff, 6'h15},
		'{OP_AND, 8'hf0, 8'h3c, 8'h0f, 8'h55, 6'h39, 8'h00, 8'h3c, 6'h33},
		'{OP_CONJUNCTION_CONST, 8'hff, 8'h3c, 8'h55, 8'h80, 6'h00, 8'h80, 8'h3c, 6'h04},
		'{OP_OR, 8'h00, 8'h3c, 8'h00, 8'h55, 6'h08, 8'h00, 8'h3c, 6'h02},
		'{OP_DISJUNCTION_CONST, 8'h01, 8'h3c, 8'h55, 8'h80, 6'h00, 8'h81, 8'h3c, 6'h04},
		'{OP_BITWISE_PARITY_REGS, 8'haa, 8'h3c, 8'haa, 8'h55, 6'h01, 8'h00, 8'h3c, 6'h03},
		'{OP_ONES_INVERT, 8'h00, 8'h3c, 8'h55, 8'h55, 6'h08, 8'hff, 8'h3c, 6'h05},
		'{OP_TWOS_INVERT, 8'h80, 8'h3c, 8'h55, 8'h55, 6'h00, 8'h80, 8'h3c, 6'h0d},
		'{OP_TWOS_INVERT, 8'h01, 8'h3c, 8'h55, 8'h55, 6'h00, 8'hff, 8'h3c, 6'h25},
		'{OP_BITS_SET_MASK, 8'h10, 8'h3c, 8'h55, 8'h01, 6'h20, 8'h11, 8'h3c, 6'h20},
		'{OP_BITS_CLEAR_MASK, 8'h8f, 8'h3c, 8'h55, 8'h0f, 6'h00, 8'h80, 8'h3c, 6'h04}};
	eal_arith_logic_unit dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy));
	eal_apb_master mst (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		mst.xfer(wr, a, wd, 1'b0, rd, er);
	endtask : bus
	// next setup cycle follows this transfer at once
	task automatic bus_hold(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		mst.xfer(wr, a, wd, 1'b1, rd, er);
	endtask : bus_hold
	task automatic run(input eal_row_t r);
		bus(1'b1, OFF_DEST, {24'h0, r.d});
		bus(1'b1, OFF_DEST_HI, {24'h0, r.dh});
		bus(1'b1, OFF_SRC, {24'h0, r.s});
		bus(1'b1, OFF_IMM, {24'h0, r.k});
		bus(1'b1, OFF_FLAGS, {26'h0, r.fi});
		bus(1'b1, OFF_CTRL, {23'h0, 1'b1, 3'h0, r.op});
		chk("start err", 32'h0, {31'h0, er});
		@(posedge ref_clk);
		chk("busy", 32'h1, {31'h0, busy});
		while (busy !== 1'b0)
			@(posedge ref_clk);
		bus(1'b0, OFF_RESULT, 32'h0);
		chk("result", {16'h0, r.edh, r.ed}, rd);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk("flags", {26'h0, r.fo}, rd);
	endtask : run
	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// a hang ends the run through the same report
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (rows[i]) run(rows[i]);
		bus(1'b0, 8'h1c, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		bus(1'b1, 8'h05, 32'hff);
		chk("misaligned err", 32'h1, {31'h0, er});
		bus(1'b1, OFF_RESULT, 32'h1234);
		chk("result write err", 32'h1, {31'h0, er});
		bus(1'b0, OFF_RESULT, 32'h0);
		chk("result kept", 32'h3c80, rd);
		bus(1'b1, OFF_FLAGS, 32'hffffffff);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk("flags width", 32'h3f, rd);
		// a write arriving in the high byte cycle of a word op is refused
		bus(1'b1, OFF_DEST, 32'hff);
		bus(1'b1, OFF_DEST_HI, 32'h00);
		bus(1'b1, OFF_IMM, 32'h01);
		bus_hold(1'b1, OFF_CTRL, {23'h0, 1'b1, 3'h0, OP_WORD_IMMEDIATE_PLUS});
		bus(1'b1, OFF_DEST, 32'h5a);
		chk("busy write err", 32'h1, {31'h0, er});
		bus(1'b0, OFF_RESULT, 32'h0);
		chk("refused write", 32'h0100, rd);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk("word flags", 32'h20, rd);
		bus_hold(1'b1, OFF_CTRL, {23'h0, 1'b1, 3'h0, OP_WORD_IMMEDIATE_MINUS});
		bus(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl busy", 32'h207, rd);
		bus(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl idle", 32'h7, rd);
		bus(1'b0, OFF_RESULT, 32'h0);
		chk("word borrow", 32'h00ff, rd);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, OFF_RESULT, 32'h0);
		chk("reset result", 32'h0, rd);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk("reset flags", {26'h0, FLAGS_RST}, rd);
		final_report();
	end
endmodule : eal_arith_logic_unit_tb
